// [src/lb2_ctrl_regs.vh]
`ifndef LB2_CTRL_REGS_VH
`define LB2_CTRL_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_DEVICE_CONFIG   8'h00
`define OFS_U_IF_CTRL       8'h04
`define OFS_ST_IF_CTRL      8'h08
`define OFS_U_IRQ           8'h0C
`define OFS_U_IRQ_MASK      8'h10
`define OFS_STATUS          8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_AUTO_EOC        4
`define BIT_ACT_TX_CTL      4
`define BIT_AUTO_ACT        5
`define BIT_ACT_MODE        6
`define BIT_IRQ_LB2         0
`define BIT_IRQ_ACT_CHG     1

// ----------------------------------------
// Status layout
// ----------------------------------------
`define ST_TRANSPARENT      0
`define ST_ACT_TX           1
`define ST_LB2              2
`define ST_U_ACTIVE         3
`define ST_ACT_RX           4
`define ST_INFO3            5
`define ST_FORCE_ONES       6

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RST_DEVICE_CONFIG   8'h10
`define RST_U_IF_CTRL       8'h20
`define RST_ST_IF_CTRL      8'h00
`define RST_U_IRQ_MASK      8'h00
`define REG_W               8
`define CTRL_BITS           3
`define ALL_ONES            8'hFF
`define ZERO_WORD           32'h0000_0000
`define ACT_MODE_ANSI       1'b0

`endif

// [src/pin_sync3.v]
`timescale 1ns/100ps

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module pin_sync3 #(
	parameter WIDTH = 3
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1;
			reg s2;
			reg s3;
			reg held;
			// First stage feeds only the second; a change counts once s2 and s3 agree
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1   <= 1'b0;
					s2   <= 1'b0;
					s3   <= 1'b0;
					held <= 1'b0;
				end else begin
					s1 <= pin_in[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						held <= s3;
					end
				end
			end
			assign pin_out[i] = held;
		end
	endgenerate

endmodule // pin_sync3

// [src/lb2_act_ctrl.v]
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`include "lb2_ctrl_regs.vh"

module lb2_act_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq,
	// Transceiver core pins
	input  wire        info3_detect,
	input  wire        act_rx,
	input  wire        u_active,
	// EOC decoder, same clock
	input  wire        eoc_lb2_cmd,
	input  wire        eoc_return_cmd,
	// Loopback data path
	input  wire [7:0]  lb_data_in,
	input  wire        lb_data_valid,
	output reg  [7:0]  lb_data_out,
	output reg         lb_data_out_valid,
	// Control outputs
	output reg         act_tx,
	output reg         bd_loop_en,
	output reg         st_loop_en,
	output reg         up_transparent,
	output reg         force_ones
);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// Core pins are asynchronous to pclk; four flops each
	wire [`CTRL_BITS-1:0] pins_sync;
	wire                  info3_s;
	wire                  act_rx_s;
	wire                  u_active_s;

	pin_sync3 #(
		.WIDTH (`CTRL_BITS)
	) i_pin_sync3 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({info3_detect, act_rx, u_active}),
		.pin_out (pins_sync)
	);

	// Split the synced bus back into named levels
	assign info3_s    = pins_sync[2];
	assign act_rx_s   = pins_sync[1];
	assign u_active_s = pins_sync[0];

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	// Software-visible bytes, one to each bus word
	reg  [`REG_W-1:0] device_config_reg;
	reg  [`REG_W-1:0] u_interface_ctrl_reg;
	reg  [`REG_W-1:0] st_interface_ctrl_reg;
	reg  [`REG_W-1:0] u_interrupt_reg;
	reg  [`REG_W-1:0] u_interrupt_mask_reg;
	reg               lb2_active;
	reg               u_active_d;

	wire              auto_eoc_processor_enable;
	wire              transmit_activation_ctl;
	wire              auto_act_enable;
	wire              act_mode_select;
	wire              mode_ansi;

	// Control fields picked out of the stored bytes
	assign auto_eoc_processor_enable = device_config_reg[`BIT_AUTO_EOC];
	assign transmit_activation_ctl   = u_interface_ctrl_reg[`BIT_ACT_TX_CTL];
	assign auto_act_enable           = u_interface_ctrl_reg[`BIT_AUTO_ACT];
	assign act_mode_select           = st_interface_ctrl_reg[`BIT_ACT_MODE];
	assign mode_ansi                 = (act_mode_select == `ACT_MODE_ANSI);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire setup_phase;
	wire access_phase;
	wire wr_en;
	wire rd_en;
	wire addr_hit;

	// Bus phase from the two strobes
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_en        = access_phase && pwrite && addr_hit;
	assign rd_en        = access_phase && !pwrite && addr_hit;

	// Every access finishes in one access cycle; no wait states needed
	assign pready  = 1'b1;
	assign pslverr = access_phase && !addr_hit;

	// Six mapped words; any other offset answers with an error
	assign addr_hit = (paddr == `OFS_DEVICE_CONFIG) ||
	                  (paddr == `OFS_U_IF_CTRL) ||
	                  (paddr == `OFS_ST_IF_CTRL) ||
	                  (paddr == `OFS_U_IRQ) ||
	                  (paddr == `OFS_U_IRQ_MASK) ||
	                  (paddr == `OFS_STATUS);

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	wire [`REG_W-1:0] status_word;

	// Live view of the decisions; top bit reads zero
	assign status_word = {1'b0,
	                      force_ones,
	                      info3_s,
	                      act_rx_s,
	                      u_active_s,
	                      lb2_active,
	                      act_tx,
	                      up_transparent};

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	reg [`REG_W-1:0] next_rd;

	// Unmapped offsets read as zero
	always @* begin
		case (paddr)
			`OFS_DEVICE_CONFIG: next_rd = device_config_reg;
			`OFS_U_IF_CTRL:     next_rd = u_interface_ctrl_reg;
			`OFS_ST_IF_CTRL:    next_rd = st_interface_ctrl_reg;
			`OFS_U_IRQ:         next_rd = u_interrupt_reg;
			`OFS_U_IRQ_MASK:    next_rd = u_interrupt_mask_reg;
			`OFS_STATUS:        next_rd = status_word;
			default:            next_rd = {`REG_W{1'b0}};
		endcase
	end

	// Read data captured in setup so it is stable for the whole access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `ZERO_WORD;
		end else if (setup_phase) begin
			prdata <= {24'h00_0000, next_rd};
		end
	end

	// ----------------------------------------
	// Control register writes
	// ----------------------------------------
	// Writes land at the access edge; pready never stretches them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_config_reg     <= `RST_DEVICE_CONFIG;
			u_interface_ctrl_reg  <= `RST_U_IF_CTRL;
			st_interface_ctrl_reg <= `RST_ST_IF_CTRL;
			u_interrupt_mask_reg  <= `RST_U_IRQ_MASK;
		end else if (wr_en) begin
			case (paddr)
				`OFS_DEVICE_CONFIG: device_config_reg     <= pwdata[`REG_W-1:0];
				`OFS_U_IF_CTRL:     u_interface_ctrl_reg  <= pwdata[`REG_W-1:0];
				`OFS_ST_IF_CTRL:    st_interface_ctrl_reg <= pwdata[`REG_W-1:0];
				`OFS_U_IRQ_MASK:    u_interrupt_mask_reg  <= pwdata[`REG_W-1:0];
				// Flag and status offsets ignore writes
				default:            device_config_reg     <= device_config_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Loopback 2 state
	// ----------------------------------------
	wire eoc_accept;
	wire lb2_start;
	wire lb2_stop;

	// Commands are only acted on by the automatic EOC processor
	assign eoc_accept = auto_eoc_processor_enable && u_active_s;
	// Entry needs a live U link, so a dead line never raises the entry flag
	assign lb2_start  = eoc_accept && eoc_lb2_cmd && !lb2_active && !eoc_return_cmd;
	// Return wins over a same-cycle entry request; link loss wins over both
	assign lb2_stop   = !u_active_s || (auto_eoc_processor_enable && eoc_return_cmd);

	// Loopback ends on return-to-normal or loss of U activation
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb2_active <= 1'b0;
		end else if (lb2_stop) begin
			lb2_active <= 1'b0;
		end else if (lb2_start) begin
			lb2_active <= 1'b1;
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	wire act_change;
	wire irq_clear;

	assign act_change = (u_active_s != u_active_d);
	assign irq_clear  = rd_en && (paddr == `OFS_U_IRQ);

	// ----------------------------------------
	// Activation change detect
	// ----------------------------------------
	// Both levels reset low, so reset release shows no false change
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			u_active_d <= 1'b0;
		end else begin
			u_active_d <= u_active_s;
		end
	end

	// Read clears; an event in the same cycle still sets the flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			u_interrupt_reg <= {`REG_W{1'b0}};
		end else begin
			if (irq_clear) begin
				u_interrupt_reg <= {`REG_W{1'b0}};
			end
			if (act_change) begin
				u_interrupt_reg[`BIT_IRQ_ACT_CHG] <= 1'b1;
			end
			if (lb2_start) begin
				u_interrupt_reg[`BIT_IRQ_LB2] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	// Mask bit set suppresses the matching flag
	assign irq = |(u_interrupt_reg & ~u_interrupt_mask_reg);

	// ----------------------------------------
	// Act bit and transparency decisions
	// ----------------------------------------
	// Decision values for the output registers
	reg  next_act_tx;
	reg  next_transparent;
	reg  next_force_ones;
	wire lb2_first;
	wire lb2_second;

	// Loopback split by the act mode select
	assign lb2_first  = lb2_active && mode_ansi;
	assign lb2_second = lb2_active && !mode_ansi;

	// Only loopback 2 separates the modes; elsewhere both take one path
	always @* begin
		next_act_tx      = info3_s;
		next_transparent = act_rx_s;
		next_force_ones  = 1'b0;
		if (lb2_first) begin
			next_act_tx      = 1'b0;
			next_transparent = 1'b1;
		end else if (lb2_second) begin
			// LT only answers act 1 after ours, so this loop closes itself
			next_act_tx      = info3_s;
			next_transparent = act_rx_s;
			next_force_ones  = !act_rx_s;
		end
		// Manual act wins in every mode, so software can hold act low
		if (!auto_act_enable) begin
			next_act_tx = transmit_activation_ctl;
		end
	end

	// ----------------------------------------
	// Registered control outputs
	// ----------------------------------------
	// Act bit and transparency move together, one edge after their inputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_tx         <= 1'b0;
			up_transparent <= 1'b0;
			force_ones     <= 1'b0;
		end else begin
			act_tx         <= next_act_tx;
			up_transparent <= next_transparent;
			force_ones     <= next_force_ones;
		end
	end

	// Both loops open and close on the same edge as the act decisions
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bd_loop_en <= 1'b0;
			st_loop_en <= 1'b0;
		end else begin
			bd_loop_en <= lb2_active;
			st_loop_en <= lb2_active;
		end
	end

	// ----------------------------------------
	// Loopback data path
	// ----------------------------------------
	// One output strobe per input word, and only while the loop is closed
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_data_out_valid <= 1'b0;
		end else begin
			lb_data_out_valid <= lb_data_valid && bd_loop_en;
		end
	end

	// Ones stand in for data until the line end confirms with act 1, except in the first loopback mode, which passes data at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_data_out       <= `ALL_ONES;
		end else begin
			if (lb_data_valid) begin
				if (force_ones || !up_transparent) begin
					lb_data_out <= `ALL_ONES;
				end else begin
					lb_data_out <= lb_data_in;
				end
			end
		end
	end

endmodule // lb2_act_ctrl

// [tb/lb2_act_chk_checker.sv]
`timescale 1ns/100ps
// --------------------------------
// Port checker for loopback control
// --------------------------------
module lb2_act_chk (
	input wire       pclk,
	input wire       presetn,
	input wire       psel,
	input wire       penable,
	input wire       pslverr,
	input wire       eoc_lb2_cmd,
	input wire       u_active,
	input wire       act_rx,
	input wire [7:0] lb_data_in,
	input wire       lb_data_valid,
	input wire [7:0] lb_data_out,
	input wire       lb_data_out_valid,
	input wire       bd_loop_en,
	input wire       st_loop_en,
	input wire       up_transparent,
	input wire       force_ones
);
	// One domain, so one clock and reset for all
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error flag outside access");
	property p_st_loop; bd_loop_en == st_loop_en; endproperty
	a_st_loop: assert property (p_st_loop) else $error("S/T loop not with data loop");
	property p_ones; force_ones |-> bd_loop_en && !up_transparent; endproperty
	a_ones: assert property (p_ones) else $error("all ones outside loop");
	// Both samples checked: tolerant of either register timing
	property p_ones_data;
		lb_data_out_valid && force_ones && $past(force_ones) |-> lb_data_out == 8'hFF;
	endproperty
	a_ones_data: assert property (p_ones_data) else $error("data not all ones");
	property p_pass;
		lb_data_out_valid && up_transparent && $past(up_transparent) && !force_ones
			&& !$past(force_ones) |-> lb_data_out == $past(lb_data_in);
	endproperty
	a_pass: assert property (p_pass) else $error("loop data altered");
	property p_valid; lb_data_out_valid |-> $past(lb_data_valid); endproperty
	a_valid: assert property (p_valid) else $error("output strobe without input");
	property p_entry; $rose(bd_loop_en) |-> $past(eoc_lb2_cmd, 2); endproperty
	a_entry: assert property (p_entry) else $error("loop without command");
	property p_transp; $rose(up_transparent) && !bd_loop_en |-> $past(act_rx, 3); endproperty
	a_transp: assert property (p_transp) else $error("transparent without act");
	property p_exit; $fell(u_active) |-> ##[1:8] !bd_loop_en; endproperty
	a_exit: assert property (p_exit) else $error("loop kept after link loss");
endmodule // lb2_act_chk

bind lb2_act_ctrl lb2_act_chk i_lb2_act_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pslverr(pslverr), .eoc_lb2_cmd(eoc_lb2_cmd), .u_active(u_active),
	.act_rx(act_rx), .lb_data_in(lb_data_in), .lb_data_valid(lb_data_valid),
	.lb_data_out(lb_data_out), .lb_data_out_valid(lb_data_out_valid),
	.bd_loop_en(bd_loop_en), .st_loop_en(st_loop_en), .up_transparent(up_transparent),
	.force_ones(force_ones));

// [tb/lt_model.sv]
`timescale 1ns/100ps
// --------------------------------
// Line termination act bit model
// --------------------------------
module lt_model (
	input wire pclk,
	input wire presetn,
	input wire link_up,
	input wire act_up,
	output reg act_down
);
	// Downstream act held 0 until upstream act seen; link loss drops it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			act_down <= 1'b0;
		else if (!link_up)
			act_down <= 1'b0;
		else if (act_up)
			act_down <= 1'b1;
	end
endmodule // lt_model

// [tb/tb_lb2_act_ctrl.sv]
`timescale 1ns/100ps
`include "lb2_ctrl_regs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
// --------------------------------
// Loopback act control bench
// --------------------------------
module tb_lb2_act_ctrl;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        info3_detect = 1'b0, u_active = 1'b0, link_up = 1'b0;
	logic        eoc_lb2_cmd = 1'b0, eoc_return_cmd = 1'b0, lb_data_valid = 1'b0;
	logic [7:0]  paddr = 8'h00, lb_data_in = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rd;
	logic        err;
	wire  [31:0] prdata;
	wire  [7:0]  lb_data_out;
	wire         pready, pslverr, irq, act_rx, lb_data_out_valid;
	wire         act_tx, bd_loop_en, st_loop_en, up_transparent, force_ones;
	int          num_errors = 0, checked = 0;

	// 250 MHz clock
	always #2 pclk = ~pclk;

	lb2_act_ctrl i_lb2_act_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.info3_detect(info3_detect), .act_rx(act_rx), .u_active(u_active),
		.eoc_lb2_cmd(eoc_lb2_cmd), .eoc_return_cmd(eoc_return_cmd),
		.lb_data_in(lb_data_in), .lb_data_valid(lb_data_valid), .lb_data_out(lb_data_out),
		.lb_data_out_valid(lb_data_out_valid), .act_tx(act_tx), .bd_loop_en(bd_loop_en),
		.st_loop_en(st_loop_en), .up_transparent(up_transparent), .force_ones(force_ones));
	lt_model i_lt_model (.pclk(pclk), .presetn(presetn), .link_up(link_up),
		.act_up(act_tx), .act_down(act_rx));

	// APB transfer; request held until pready seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e, input string n);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(n, {24'h00_0000, e}, rd)
	endtask
	// Sync chain plus output register fits in eight edges
	task settle;
		repeat (8) @(posedge pclk);
	endtask
	task eoc(input logic ret);
		@(posedge pclk);
		eoc_lb2_cmd <= !ret;
		eoc_return_cmd <= ret;
		@(posedge pclk);
		eoc_lb2_cmd <= 1'b0;
		eoc_return_cmd <= 1'b0;
		settle;
	endtask
	task send(input logic [7:0] d, input logic [7:0] e);
		@(posedge pclk);
		lb_data_in <= d;
		lb_data_valid <= 1'b1;
		@(posedge pclk);
		lb_data_valid <= 1'b0;
		@(negedge pclk);
		`CHK("lb_data_out", e, lb_data_out)
		`CHK("lb_data_out_valid", 1'b1, lb_data_out_valid)
		@(posedge pclk);
	endtask

	task t_regs;
		rchk(`OFS_DEVICE_CONFIG, `RST_DEVICE_CONFIG, "config");
		rchk(`OFS_U_IF_CTRL, `RST_U_IF_CTRL, "u_ctrl");
		rchk(`OFS_ST_IF_CTRL, `RST_ST_IF_CTRL, "st_ctrl");
		rchk(`OFS_U_IRQ_MASK, `RST_U_IRQ_MASK, "mask");
		rchk(8'h40, 8'h00, "unmapped");
		`CHK("pslverr", 1'b1, err)
		$display("test regs done");
	endtask
	task t_normal;
		u_active <= 1'b1;
		link_up <= 1'b1;
		settle;
		`CHK("up_transparent", 1'b0, up_transparent)
		info3_detect <= 1'b1;
		settle;
		settle;
		`CHK("act_tx", 1'b1, act_tx)
		`CHK("up_transparent", 1'b1, up_transparent)
		apb(1'b1, `OFS_U_IF_CTRL, 32'h0000_0000);
		settle;
		`CHK("act_tx", 1'b0, act_tx)
		apb(1'b1, `OFS_U_IF_CTRL, 32'h0000_0010);
		settle;
		`CHK("act_tx", 1'b1, act_tx)
		apb(1'b1, `OFS_U_IF_CTRL, 32'h0000_0020);
		rchk(`OFS_U_IRQ, 8'h02, "irq_act");
		rchk(`OFS_U_IRQ, 8'h00, "irq_clear");
		$display("test normal done");
	endtask
	task t_ansi;
		link_up <= 1'b0;
		settle;
		eoc(1'b0);
		`CHK("bd_loop_en", 1'b1, bd_loop_en)
		`CHK("st_loop_en", 1'b1, st_loop_en)
		`CHK("act_tx", 1'b0, act_tx)
		`CHK("up_transparent", 1'b1, up_transparent)
		`CHK("irq", 1'b1, irq)
		send(8'hA5, 8'hA5);
		rchk(`OFS_U_IRQ, 8'h01, "irq_lb2");
		eoc(1'b1);
		`CHK("bd_loop_en", 1'b0, bd_loop_en)
		$display("test first mode done");
	endtask
	task t_etsi;
		apb(1'b1, `OFS_ST_IF_CTRL, 32'h0000_0040);
		rchk(`OFS_ST_IF_CTRL, 8'h40, "st_ctrl");
		eoc(1'b0);
		`CHK("act_tx", 1'b1, act_tx)
		`CHK("force_ones", 1'b1, force_ones)
		send(8'h3C, 8'hFF);
		link_up <= 1'b1;
		settle;
		`CHK("up_transparent", 1'b1, up_transparent)
		send(8'h3C, 8'h3C);
		info3_detect <= 1'b0;
		settle;
		`CHK("act_tx", 1'b0, act_tx)
		eoc(1'b1);
		`CHK("force_ones", 1'b0, force_ones)
		`CHK("up_transparent", 1'b1, up_transparent)
		`CHK("act_tx", 1'b0, act_tx)
		info3_detect <= 1'b1;
		$display("test second mode done");
	endtask
	task t_irq;
		apb(1'b1, `OFS_U_IRQ_MASK, 32'h0000_0002);
		apb(1'b0, `OFS_U_IRQ, 32'h0000_0000);
		u_active <= 1'b0;
		settle;
		`CHK("irq", 1'b0, irq)
		rchk(`OFS_U_IRQ, 8'h02, "irq_masked");
		apb(1'b1, `OFS_U_IRQ_MASK, 32'h0000_0000);
		u_active <= 1'b1;
		settle;
		`CHK("irq", 1'b1, irq)
		apb(1'b0, `OFS_U_IRQ, 32'h0000_0000);
		settle;
		`CHK("irq", 1'b0, irq)
		$display("test interrupt done");
	endtask
	task t_noeoc;
		apb(1'b1, `OFS_DEVICE_CONFIG, 32'h0000_0000);
		eoc(1'b0);
		`CHK("bd_loop_en", 1'b0, bd_loop_en)
		$display("test eoc disable done");
	endtask

	task conclude;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_normal;
		t_ansi;
		t_etsi;
		t_irq;
		t_noeoc;
		conclude;
	end
	// Watchdog: tests need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		conclude;
	end
endmodule // tb_lb2_act_ctrl
